// [srs_reset_seq.sv]
`timescale 1ns/1ns
// Functional notes
// R1: Low pulse over 1032 half-cycles is long.
// R2: Low pulse 4 to 1032 half-cycles is short.
// R3: Five sources, each with own config latch; code latches all bits, or only 12:8 for soft/watchdog.
// R4: Reset pin low, select low: reset immediately.
// R5: Async entry: outputs low, abort, tristate, pullup.
// R6: Async detection needs no running clock.
// R7: Power-on: outside holds both pins low.
// R8: Exit latches config, forces strobes idle.
// R9: Fetch restarts at address zero, segment zero.
// R10: Latch 6 or 8 half-cycles after rise.
// R11: Sync reset needs pin low over 4.
// R12: Sync entry tristates, 12 half-cycle abort window.
// R13: Bidir bit drives pulldown; cleared after reset.
// R14: Sequence 1024 half-cycles, extended while pin low.
// R15: Select falling during sync switches to async.
// R16: Software reset instruction acts like sync reset.
// R17: Soft/watchdog latch bits 12:8, clear 7:2.
// R18: Watchdog overflow starts the reset sequence.
// R19: Watchdog lets bus cycle finish unless ready high.
// R20: Reset output low until end-of-init executes.
// R21: Counters run in half-cycles, two per clock.
// R22: Select input is a digital level.
module srs_reset_seq (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_reset_in_n,
   input wire logic vpp_level,
   output logic ext_reset_pd_out,
   output logic ext_reset_pd_oe,
   output logic reset_out_n,
   input wire logic [15:0] config_port,
   input wire logic pll_bypass_presc,
   input wire logic software_reset_instr,
   input wire logic end_init_instr,
   input wire logic watchdog_overflow,
   input wire srs_pkg::srs_bus_stat_s bus_stat,
   output srs_pkg::srs_bus_ctl_s bus_ctl,
   output logic cpu_reset,
   output logic fetch_start,
   output logic [23:0] fetch_addr,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);

   // ----------------------------------------------------------------
   // Asynchronous reset request
   // ----------------------------------------------------------------
   // R4 async entry
   // R6 clockless detect
   // R22 digital select
   logic async_rst_n;
   assign async_rst_n = ext_reset_in_n | vpp_level;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic rin_s1;
   logic rin_s2;
   logic [15:0] port_s1;
   logic [15:0] port_s2;

   always_ff @(posedge clk or negedge async_rst_n) begin
      if (!async_rst_n) begin
         rin_s1 <= 1'b0;
         rin_s2 <= 1'b0;
         port_s1 <= srs_pkg::CFG_RESET;
         port_s2 <= srs_pkg::CFG_RESET;
      end else begin
         rin_s1 <= ext_reset_in_n;
         rin_s2 <= rin_s1;
         port_s1 <= config_port;
         port_s2 <= port_s1;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer state and registers
   // ----------------------------------------------------------------
   srs_pkg::srs_state_e state;
   srs_pkg::srs_state_e next_state;
   srs_pkg::srs_src_e src;
   srs_pkg::srs_src_e next_src;
   srs_pkg::srs_tcl_t cnt;
   srs_pkg::srs_tcl_t next_cnt;
   srs_pkg::srs_tcl_t pw;
   srs_pkg::srs_tcl_t next_pw;
   logic [15:0] syscfg;
   logic [15:0] next_syscfg;
   logic [15:0] cfg_lat;
   logic [15:0] next_cfg_lat;
   logic next_reset_out_n;
   logic next_pd_oe;
   logic next_cpu_reset;
   logic next_fetch_start;
   srs_pkg::srs_bus_ctl_s next_bus_ctl;
   logic next_ack;
   logic [31:0] next_dat;
   logic wdt_abort;
   logic pin_req;
   srs_pkg::srs_tcl_t cnt_inc;
   srs_pkg::srs_tcl_t latch_tcl;

   always_comb begin
      next_state = state;
      next_src = src;
      next_cnt = cnt;
      next_pw = pw;
      next_syscfg = syscfg;
      next_cfg_lat = cfg_lat;
      next_reset_out_n = reset_out_n;
      next_pd_oe = ext_reset_pd_oe;
      next_cpu_reset = cpu_reset;
      next_fetch_start = 1'b0;
      next_ack = 1'b0;
      next_dat = 32'h0000_0000;
      wdt_abort = 1'b0;
      cnt_inc = srs_tcl_t_add(cnt);
      // R10 latch delay
      latch_tcl = pll_bypass_presc ? srs_pkg::LATCH_FAST_TCL : srs_pkg::LATCH_SLOW_TCL;

      // R21 half-cycle width
      if (!rin_s2) begin
         next_pw = (pw < srs_pkg::PW_MAX_TCL) ? srs_tcl_t_add(pw) : pw;
      end else begin
         next_pw = '0;
      end
      // R11 minimum low time
      // Judged on the updated width so a 3rd synced low clock qualifies
      pin_req = !rin_s2 && (next_pw > srs_pkg::SHORT_MIN_TCL);

      // Software access; hardware clear below takes precedence
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_adr_i == srs_pkg::ADDR_SYSCFG)) begin
         if (wb_sel_i[0]) begin
            next_syscfg[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            next_syscfg[15:8] = wb_dat_i[15:8];
         end
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         next_ack = 1'b1;
         case (wb_adr_i)
            srs_pkg::ADDR_SYSCFG: next_dat = {16'h0000, syscfg};
            srs_pkg::ADDR_STATUS: next_dat = {22'h00_0000, cpu_reset, reset_out_n, 1'b0,
                                              state, 1'b0, src};
            srs_pkg::ADDR_CONFIG: next_dat = {16'h0000, cfg_lat};
            default: next_dat = 32'h0000_0000;
         endcase
      end

      // R1 long classification
      if ((state != srs_pkg::ST_RUN) && (src == srs_pkg::SRC_SHORT_HW) &&
          (pw > srs_pkg::LONG_MIN_TCL)) begin
         next_src = srs_pkg::SRC_LONG_HW;
      end

      case (state)
         srs_pkg::ST_RUN: begin
            // R20 release on end-of-init
            if (end_init_instr) begin
               next_reset_out_n = 1'b1;
            end
            if (pin_req || software_reset_instr) begin
               // R2 short classification
               // R16 software like sync
               // R12 sync entry
               next_src = pin_req ? srs_pkg::SRC_SHORT_HW : srs_pkg::SRC_SOFTWARE;
               next_state = srs_pkg::ST_SYNC_ENTRY;
               next_cnt = '0;
               next_reset_out_n = 1'b0;
               next_cpu_reset = 1'b1;
               // R13 bidir pulldown
               next_pd_oe = syscfg[srs_pkg::BIDIR_BIT];
            end else if (watchdog_overflow) begin
               // R18 watchdog start
               next_src = srs_pkg::SRC_WATCHDOG;
               next_reset_out_n = 1'b0;
               next_cpu_reset = 1'b1;
               next_cnt = '0;
               next_pd_oe = syscfg[srs_pkg::BIDIR_BIT];
               // R19 bus completion
               if (!bus_stat.cycle_busy) begin
                  next_state = srs_pkg::ST_SEQUENCE;
               end else if (bus_stat.ready_used && bus_stat.ready_done && bus_stat.ready_level) begin
                  wdt_abort = 1'b1;
                  next_state = srs_pkg::ST_SEQUENCE;
               end else begin
                  next_state = srs_pkg::ST_WDT_WAIT;
               end
            end
         end
         srs_pkg::ST_WDT_WAIT: begin
            // R19 wait or abort
            if (pin_req) begin
               next_src = srs_pkg::SRC_SHORT_HW;
               next_state = srs_pkg::ST_SYNC_ENTRY;
               next_cnt = '0;
            end else if (!bus_stat.cycle_busy) begin
               next_state = srs_pkg::ST_SEQUENCE;
               next_cnt = '0;
            end else if (bus_stat.ready_used && bus_stat.ready_done && bus_stat.ready_level) begin
               wdt_abort = 1'b1;
               next_state = srs_pkg::ST_SEQUENCE;
               next_cnt = '0;
            end
         end
         srs_pkg::ST_SYNC_ENTRY: begin
            // R12 twelve half-cycle window
            next_cnt = cnt_inc;
            if (cnt_inc >= srs_pkg::ENTRY_TCL) begin
               next_state = srs_pkg::ST_SEQUENCE;
               next_cnt = '0;
            end
         end
         srs_pkg::ST_SEQUENCE: begin
            // R14 fixed sequence
            next_cnt = cnt_inc;
            if (cnt_inc >= srs_pkg::SEQ_TCL) begin
               next_state = srs_pkg::ST_EXTEND;
               next_cnt = '0;
               // Release own pulldown so the pin level can be judged
               next_pd_oe = 1'b0;
            end
         end
         srs_pkg::ST_EXTEND: begin
            // R14 extend while low
            if (cnt < srs_pkg::SETTLE_TCL) begin
               next_cnt = cnt_inc;
            end else if (rin_s2) begin
               next_state = srs_pkg::ST_LATCH_WAIT;
               next_cnt = srs_pkg::SYNC_LAG_TCL;
            end
         end
         srs_pkg::ST_ASYNC_HOLD: begin
            if (rin_s2) begin
               next_state = srs_pkg::ST_LATCH_WAIT;
               next_cnt = srs_pkg::SYNC_LAG_TCL;
            end
         end
         srs_pkg::ST_LATCH_WAIT: begin
            next_cnt = cnt_inc;
            if (cnt_inc >= latch_tcl) begin
               // R8 config latch
               // R17 partial latch
               // R3 per-source behaviour
               if ((src == srs_pkg::SRC_SOFTWARE) || (src == srs_pkg::SRC_WATCHDOG)) begin
                  next_cfg_lat = (cfg_lat & ~(srs_pkg::CFG_SOFT_LATCH | srs_pkg::CFG_SOFT_CLEAR)) |
                                 (port_s2 & srs_pkg::CFG_SOFT_LATCH);
               end else begin
                  next_cfg_lat = port_s2;
               end
               // R13 cleared after sequence
               next_syscfg[srs_pkg::BIDIR_BIT] = 1'b0;
               next_pd_oe = 1'b0;
               next_cpu_reset = 1'b0;
               // R9 restart fetch
               next_fetch_start = 1'b1;
               next_state = srs_pkg::ST_RUN;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = srs_pkg::ST_ASYNC_HOLD;
            next_cnt = '0;
         end
      endcase

      // R5 entry actions
      // R8 strobes idle
      next_bus_ctl.hold_cancel = (next_state == srs_pkg::ST_SYNC_ENTRY);
      next_bus_ctl.bus_abort = (next_state == srs_pkg::ST_SYNC_ENTRY) || wdt_abort;
      next_bus_ctl.io_tristate = (next_state != srs_pkg::ST_RUN) &&
                                 (next_state != srs_pkg::ST_WDT_WAIT);
      next_bus_ctl.cfg_pullup = next_bus_ctl.io_tristate;
      next_bus_ctl.strobe_idle = next_bus_ctl.io_tristate;
   end

   function automatic srs_pkg::srs_tcl_t srs_tcl_t_add(input srs_pkg::srs_tcl_t v);
      srs_tcl_t_add = srs_pkg::srs_tcl_t'(v + srs_pkg::TCL_STEP);
   endfunction : srs_tcl_t_add

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   // R15 async overrides sync
   always_ff @(posedge clk or negedge async_rst_n) begin
      if (!async_rst_n) begin
         state <= srs_pkg::ST_ASYNC_HOLD;
         src <= srs_pkg::SRC_LONG_HW;
         cnt <= '0;
         pw <= '0;
         syscfg <= srs_pkg::SYSCFG_RESET;
         cfg_lat <= srs_pkg::CFG_RESET;
         reset_out_n <= 1'b0;
         ext_reset_pd_oe <= 1'b0;
         ext_reset_pd_out <= 1'b0;
         cpu_reset <= 1'b1;
         fetch_start <= 1'b0;
         fetch_addr <= srs_pkg::FETCH_VECTOR;
         bus_ctl <= 5'h1F;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (rst) begin
         state <= srs_pkg::ST_ASYNC_HOLD;
         src <= srs_pkg::SRC_POWER_ON;
         cnt <= '0;
         pw <= '0;
         syscfg <= srs_pkg::SYSCFG_RESET;
         cfg_lat <= srs_pkg::CFG_RESET;
         reset_out_n <= 1'b0;
         ext_reset_pd_oe <= 1'b0;
         ext_reset_pd_out <= 1'b0;
         cpu_reset <= 1'b1;
         fetch_start <= 1'b0;
         fetch_addr <= srs_pkg::FETCH_VECTOR;
         bus_ctl <= 5'h1E;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         state <= next_state;
         src <= next_src;
         cnt <= next_cnt;
         pw <= next_pw;
         syscfg <= next_syscfg;
         cfg_lat <= next_cfg_lat;
         reset_out_n <= next_reset_out_n;
         ext_reset_pd_oe <= next_pd_oe;
         ext_reset_pd_out <= 1'b0;
         cpu_reset <= next_cpu_reset;
         fetch_start <= next_fetch_start;
         fetch_addr <= srs_pkg::FETCH_VECTOR;
         bus_ctl <= next_bus_ctl;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

endmodule : srs_reset_seq

// [srs_pkg.sv]
package srs_pkg;

   // ----------------------------------------------------------------
   // Timing in half-cycles of the CPU clock
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int HALF_CYCLES_PER_CLK = 2;
   typedef logic [10:0] srs_tcl_t;
   localparam srs_tcl_t TCL_STEP = srs_tcl_t'(HALF_CYCLES_PER_CLK);
   localparam srs_tcl_t SHORT_MIN_TCL = 11'h004;
   localparam srs_tcl_t LONG_MIN_TCL = 11'h408;
   localparam srs_tcl_t ENTRY_TCL = 11'h00C;
   localparam srs_tcl_t SEQ_TCL = 11'h400;
   localparam srs_tcl_t LATCH_FAST_TCL = 11'h006;
   localparam srs_tcl_t LATCH_SLOW_TCL = 11'h008;
   // Two synchroniser stages already elapsed when a pin edge is seen
   localparam srs_tcl_t SYNC_LAG_TCL = 11'h004;
   localparam srs_tcl_t SETTLE_TCL = 11'h004;
   localparam srs_tcl_t PW_MAX_TCL = 11'h40A;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SYSCFG = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CONFIG = 8'h08;
   localparam logic [15:0] SYSCFG_RESET = 16'h0000;
   localparam int BIDIR_BIT = 5;
   localparam logic [15:0] CFG_SOFT_LATCH = 16'h1F00;
   localparam logic [15:0] CFG_SOFT_CLEAR = 16'h00FC;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [23:0] FETCH_VECTOR = 24'h00_0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_POWER_ON = 3'h0,
      SRC_LONG_HW = 3'h1,
      SRC_SHORT_HW = 3'h2,
      SRC_WATCHDOG = 3'h3,
      SRC_SOFTWARE = 3'h4
   } srs_src_e;

   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_SYNC_ENTRY = 3'h1,
      ST_SEQUENCE = 3'h3,
      ST_EXTEND = 3'h2,
      ST_LATCH_WAIT = 3'h6,
      ST_ASYNC_HOLD = 3'h7,
      ST_WDT_WAIT = 3'h5
   } srs_state_e;

   typedef struct packed {
      logic hold_cancel;
      logic bus_abort;
      logic io_tristate;
      logic cfg_pullup;
      logic strobe_idle;
   } srs_bus_ctl_s;

   typedef struct packed {
      logic cycle_busy;
      logic ready_used;
      logic ready_done;
      logic ready_level;
   } srs_bus_stat_s;

endpackage : srs_pkg

// [srs_reset_seq_asserts.sv]
`timescale 1ns/1ns
module srs_reset_seq_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_reset_in_n,
   input wire logic vpp_level,
   input wire logic ext_reset_pd_out,
   input wire logic ext_reset_pd_oe,
   input wire logic reset_out_n,
   input wire logic end_init_instr,
   input wire srs_pkg::srs_bus_ctl_s bus_ctl,
   input wire logic cpu_reset,
   input wire logic fetch_start,
   input wire logic [23:0] fetch_addr
);
   logic armed;
   logic [10:0] cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----
   // Helper
   // ----
   // Only warm entries arm it; async exit skips the long count
   always_ff @(posedge clk) begin
      armed <= !rst && ((bus_ctl.hold_cancel && bus_ctl.strobe_idle && vpp_level) ||
                        (armed && cpu_reset));
      cnt <= bus_ctl.hold_cancel ? 11'h000 : cnt + 11'(cpu_reset);
   end
   // ----
   // Properties
   // ----
   property p_out_low; cpu_reset |-> !reset_out_n; endproperty
   a_out_low: assert property (p_out_low) else $error("reset out high in reset");
   property p_out_rel; $rose(reset_out_n) |-> $past(end_init_instr) && !cpu_reset; endproperty
   a_out_rel: assert property (p_out_rel) else $error("reset out rose early");
   property p_vec; fetch_start |-> fetch_addr == 24'h00_0000 && !cpu_reset; endproperty
   a_vec: assert property (p_vec) else $error("bad fetch vector");
   property p_strobe; fetch_start |-> $past(bus_ctl.strobe_idle) && $past(cpu_reset); endproperty
   a_strobe: assert property (p_strobe) else $error("strobes not idle at exit");
   property p_async;
      !ext_reset_in_n && !vpp_level |-> cpu_reset && !reset_out_n && bus_ctl == 5'h1F;
   endproperty
   a_async: assert property (p_async) else $error("async entry incomplete");
   property p_entry;
      $rose(bus_ctl.hold_cancel) && !$past(cpu_reset) && vpp_level
         |-> bus_ctl.hold_cancel[*6] ##1 !bus_ctl.hold_cancel;
   endproperty
   a_entry: assert property (p_entry) else $error("entry window length");
   property p_seq_len; $fell(cpu_reset) && armed |-> cnt >= 11'h200; endproperty
   a_seq_len: assert property (p_seq_len) else $error("sequence too short");
   property p_sync; (!ext_reset_in_n && vpp_level)[*3] |-> ##[0:6] cpu_reset; endproperty
   a_sync: assert property (p_sync) else $error("warm reset missed");
   property p_short;
      $rose(ext_reset_in_n) && $past(ext_reset_in_n, 3) && !cpu_reset && vpp_level
         |-> !cpu_reset[*6];
   endproperty
   a_short: assert property (p_short) else $error("short glitch caused reset");
   property p_pd; ext_reset_pd_oe |-> cpu_reset && !ext_reset_pd_out; endproperty
   a_pd: assert property (p_pd) else $error("pulldown outside reset");
endmodule : srs_reset_seq_asserts

// [srs_ext_ckt.sv]
`timescale 1ns/1ns
module srs_ext_ckt (
   input wire logic drive_low,
   input wire logic pd_oe,
   input wire logic pd_out,
   output logic pin_n
);
   // wired reset pin
   // Pullup wins only when neither side pulls low
   assign pin_n = !(drive_low || (pd_oe && !pd_out));
endmodule : srs_ext_ckt

// [srs_tb.sv]
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0, rst = 1'b1, drive_low = 1'b1, vpp_level = 1'b0, pll = 1'b0;
   logic sw_rst = 1'b0, end_init = 1'b0, wdt = 1'b0, pd_seen = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic pin_n, pd_out, pd_oe, reset_out_n, cpu_reset, fetch_start, wb_ack_o;
   logic [15:0] config_port = 16'h3925, exp_cfg = 16'h3925;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [23:0] fetch_addr;
   logic [31:0] wb_dat = 32'h0, wb_dat_o, rd, q, seed = 32'h105c_3925;
   srs_pkg::srs_bus_stat_s bus_stat = '0;
   srs_pkg::srs_bus_ctl_s bus_ctl;
   int error_cnt = 0, tests_run = 0, n;
   int wid[3] = '{2, 20, 600};
   always #25 clk = ~clk;
   always @(posedge clk) if (pd_oe === 1'b1) pd_seen <= 1'b1;
   srs_reset_seq uut (.clk(clk), .rst(rst), .ext_reset_in_n(pin_n), .vpp_level(vpp_level),
      .ext_reset_pd_out(pd_out), .ext_reset_pd_oe(pd_oe), .reset_out_n(reset_out_n),
      .config_port(config_port), .pll_bypass_presc(pll), .software_reset_instr(sw_rst),
      .end_init_instr(end_init), .watchdog_overflow(wdt), .bus_stat(bus_stat),
      .bus_ctl(bus_ctl), .cpu_reset(cpu_reset), .fetch_start(fetch_start),
      .fetch_addr(fetch_addr), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));
   srs_ext_ckt u_ext (.drive_low(drive_low), .pd_oe(pd_oe), .pd_out(pd_out), .pin_n(pin_n));
   // ----
   // Helpers
   // ----
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   // Held until ack is sampled, then released for one idle cycle
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'hF;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      chk("wb_ack", 0, k >= 20);
   endtask : wb
   task wait_run;
      n = 0;
      while (fetch_start !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk("fetch_wait", 0, n >= 3000);
      chk("fetch_addr", 0, fetch_addr);
      chk("reset_out", 0, reset_out_n);
   endtask : wait_run
   task after_rst(input string nm, input logic [2:0] src);
      wb(1'b0, 8'h08, 32'h0);
      chk("cfg_latch", exp_cfg, rd[15:0]);
      wb(1'b0, 8'h04, 32'h0);
      if (src != 3'h7) chk("source", src, rd[2:0]);
      @(posedge clk);
      end_init <= 1'b1;
      @(posedge clk);
      end_init <= 1'b0;
      @(posedge clk);
      chk("reset_out_rel", 1, reset_out_n);
      $display("test %s done", nm);
   endtask : after_rst
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      drive_low <= 1'b0;
      wait_run;
      after_rst("power_on", 3'h7);
      vpp_level <= 1'b1;
      seed = lfsr(seed);
      wb(1'b1, 8'h00, seed);
      wb(1'b0, 8'h00, 32'h0);
      chk("syscfg", seed[15:0], rd[15:0]);
      wb(1'b0, 8'h04, 32'h0);
      q = rd;
      wb(1'b1, 8'h04, ~seed);
      wb(1'b0, 8'h04, 32'h0);
      chk("status_ro", q, rd);
      wb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", 0, rd);
      $display("test regs done");
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         config_port <= seed[15:0];
         pll <= seed[16];
         if (i == 2) wb(1'b1, 8'h00, seed | 32'h0000_0020);
         @(posedge clk);
         drive_low <= 1'b1;
         repeat (wid[i]) @(posedge clk);
         drive_low <= 1'b0;
         if (i == 0) begin
            repeat (10) @(posedge clk);
            chk("glitch", 0, cpu_reset);
         end else begin
            exp_cfg = seed[15:0];
            wait_run;
            after_rst("hw_pulse", i == 1 ? 3'h2 : 3'h1);
         end
      end
      wb(1'b0, 8'h00, 32'h0);
      chk("bidir_clear", 0, rd[5]);
      chk("pulldown", 1, pd_seen);
      seed = lfsr(seed);
      config_port <= seed[15:0];
      @(posedge clk);
      sw_rst <= 1'b1;
      @(posedge clk);
      sw_rst <= 1'b0;
      exp_cfg = (exp_cfg & 16'hE003) | (seed[15:0] & 16'h1F00);
      wait_run;
      chk("seq_len", 1, n >= 518);
      after_rst("software", 3'h4);
      seed = lfsr(seed);
      config_port <= seed[15:0];
      bus_stat <= 4'hC;
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      repeat (4) @(posedge clk);
      wb(1'b0, 8'h04, 32'h0);
      chk("wdt_wait", 3'h5, rd[6:4]);
      bus_stat <= 4'hF;
      exp_cfg = (exp_cfg & 16'hE003) | (seed[15:0] & 16'h1F00);
      wait_run;
      bus_stat <= 4'h0;
      after_rst("watchdog", 3'h3);
      @(posedge clk);
      vpp_level <= 1'b0;
      drive_low <= 1'b1;
      #10 chk("async_entry", 1, cpu_reset);
      repeat (8) @(posedge clk);
      drive_low <= 1'b0;
      exp_cfg = config_port;
      wait_run;
      after_rst("async", 3'h1);
      vpp_level <= 1'b1;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      exp_cfg = config_port;
      wait_run;
      after_rst("power_on_warm", 3'h0);
      stop_test;
   end
   initial begin
      repeat (10000) @(posedge clk);
      error_cnt++;
      stop_test;
   end
endmodule : testbench
bind srs_reset_seq srs_reset_seq_asserts u_chk (.clk, .rst, .ext_reset_in_n, .vpp_level,
   .ext_reset_pd_out, .ext_reset_pd_oe, .reset_out_n, .end_init_instr, .bus_ctl,
   .cpu_reset, .fetch_start, .fetch_addr);
